// file: hw/wedg_top.sv
// Waveform store, event generators and drive/compare event logic, four channels
`timescale 1ns/100ps
module wedg_top
   import wedg_pkg::*;
#(
   parameter int RTC_STAGES = RTC_DEPTH
)
(
   // Clock and resets
   input  wire logic                          core_clk_in,
   input  wire logic                          rst_in,
   input  wire logic                          por_n_in,
   input  wire logic                          clock_generation_mode_pin_in,
   // APB slave
   input  wire logic                          psel_in,
   input  wire logic                          penable_in,
   input  wire logic                          pwrite_in,
   input  wire logic [11:0]                   paddr_in,
   input  wire logic [31:0]                   pwdata_in,
   output logic      [31:0]                   prdata_out,
   output logic                               pready_out,
   output logic                               pslverr_out,
   // Pattern sequencer
   input  wire logic [NUM_CH*WORD_W-1:0]      pattern_word_in,
   input  wire logic                          pattern_qualifier_in,
   input  wire logic                          tester_period_start_in,
   input  wire logic                          alternate_period_start_in,
   input  wire logic [OFFSET_W-1:0]           global_offset_in,
   // Timing edges, one per generator, channel major
   output logic      [NUM_CH*NUM_GEN-1:0]     edge_fire_out,
   output logic      [NUM_CH*NUM_GEN*FINE_W-1:0] edge_fine_out,
   // Compare strobes after round trip compensation
   output logic      [NUM_CH*NUM_GEN-1:0]     compare_strobe_out,
   output logic      [NUM_CH*NUM_GEN*CODE_W-1:0] compare_code_out,
   // Driver state and open windows
   output logic      [NUM_CH-1:0]             drive_data_out,
   output logic      [NUM_CH-1:0]             drive_enable_out,
   output logic      [NUM_CH-1:0]             load_enable_out,
   output logic      [NUM_CH*2-1:0]           window_open_out
);

   localparam int NG = NUM_CH * NUM_GEN;

   // Vernier code to sixtieths of the coarse step, rounded to nearest
   function automatic logic [FINE_W-1:0] vern_map(input logic [VERN_W-1:0] v);
      logic [12:0] p;
      p = 13'(v) * 13'(VERN_DIV) + 13'(VERN_SCALE / 2);
      return p[11:6];
   endfunction

   // Power-on reset synchroniser; the pin is asynchronous to the core
   logic por_meta_r;
   logic por_sync_r;
   logic rst;

   always_ff @(posedge core_clk_in)
   begin
      por_meta_r <= por_n_in;
      por_sync_r <= por_meta_r;
   end

   assign rst = rst_in | ~por_sync_r;

   // Software registers
   logic [31:0]       ctrl_r;
   logic [31:0]       wave_addr_r;
   logic [CAL_W-1:0]  cal_r [16];
   logic [EVT_W-1:0]  store [NUM_CH][NUM_WAVES][NUM_GEN];
   logic [31:0]       prdata_r;
   logic              pslverr_r;

   // APB decode
   wire               setup_ph   = psel_in & ~penable_in;
   wire               access_ph  = psel_in & penable_in;
   wire               hit_ctrl   = paddr_in == REG_CTRL;
   wire               hit_status = paddr_in == REG_STATUS;
   wire               hit_waddr  = paddr_in == REG_WAVE_ADDR;
   wire               hit_wdata  = paddr_in == REG_WAVE_DATA;
   wire               hit_cal    = paddr_in >= REG_CAL_BASE &&
                                   paddr_in <= REG_CAL_LAST &&
                                   paddr_in[1:0] == 2'b00;
   wire               hit_any    = hit_ctrl | hit_status | hit_waddr |
                                   hit_wdata | hit_cal;
   wire [3:0]         cal_idx    = 4'((paddr_in - REG_CAL_BASE) >> 2);
   wire               wr_ok      = access_ph & pwrite_in & hit_any;
   wire [1:0]         sw_ch      = wave_addr_r[WA_CH_LSB +: 2];
   wire [7:0]         sw_ent     = wave_addr_r[WA_ENT_LSB +: 8];
   wire [1:0]         sw_evt     = wave_addr_r[WA_EVT_LSB +: 2];
   wire [EVT_W-1:0]   sw_rd_word = store[sw_ch][sw_ent][sw_evt];
   wire [NUM_GEN-1:0] alt_sel    = ctrl_r[CTRL_ALT_LSB +: NUM_GEN];
   wire [RTC_W-1:0]   rtc_sel    = ctrl_r[CTRL_RTC_LSB +: RTC_W];
   wire [31:0]        status_word;
   logic [31:0]       rd_mux;

   assign status_word = (32'(drive_data_out)   << ST_DATA_LSB) |
                        (32'(drive_enable_out) << ST_EN_LSB)   |
                        (32'(load_enable_out)  << ST_LOAD_LSB) |
                        (32'(window_open_out)  << ST_WIN_LSB)  |
                        (32'(clock_generation_mode_pin_in) << ST_MODE_BIT);

   // Read selection; unmapped offsets read zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl)
         rd_mux = ctrl_r;
      else if (hit_status)
         rd_mux = status_word;
      else if (hit_waddr)
         rd_mux = wave_addr_r;
      else if (hit_wdata)
         rd_mux = 32'(sw_rd_word);
      else if (hit_cal)
         rd_mux = 32'(cal_r[cal_idx]);
   end

   // Read data caught in setup so the access phase needs no wait state
   always_ff @(posedge core_clk_in)
   begin
      if (rst)
      begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else if (setup_ph)
      begin
         prdata_r  <= rd_mux;
         pslverr_r <= ~hit_any;
      end
   end

   assign prdata_out  = prdata_r;
   assign pslverr_out = pslverr_r;
   assign pready_out  = 1'b1;

   // Control, address and calibration registers
   always_ff @(posedge core_clk_in)
   begin
      if (rst)
      begin
         ctrl_r      <= CTRL_RESET;
         wave_addr_r <= 32'h0000_0000;
         for (int i = 0; i < 16; i++)
            cal_r[i] <= 8'h00;
      end
      else if (wr_ok)
      begin
         if (hit_ctrl)
            ctrl_r <= pwdata_in & CTRL_MASK;
         if (hit_waddr)
            wave_addr_r <= pwdata_in & WA_MASK;
         if (hit_cal)
            cal_r[cal_idx] <= pwdata_in[CAL_W-1:0];
      end
   end

   // Software port of the store; the pattern port only reads, no reset
   always_ff @(posedge core_clk_in)
   begin
      if (wr_ok && hit_wdata)
         store[sw_ch][sw_ent][sw_evt] <= pwdata_in[EVT_W-1:0];
   end

   // Timing edge and compare delay state
   logic [COARSE_W-1:0] cnt_r    [NG];
   logic [NG-1:0]       armed_r;
   logic [CODE_W-1:0]   code_r   [NG];
   logic [FINE_W-1:0]   fine_r   [NG];
   logic [NG-1:0]       fire_r;
   logic [NG-1:0]       fire_now;
   logic [RTC_STAGES-1:0] cmp_pipe_r [NG];
   logic [CODE_W-1:0]   cmp_code_pipe_r [NG][RTC_STAGES];
   logic [NG-1:0]       cmp_tap;
   logic [CODE_W-1:0]   cmp_tap_code [NG];
   logic [NG-1:0]       strobe_r;
   logic [CODE_W-1:0]   strobe_code_r [NG];

   genvar gi;
   generate
      for (gi = 0; gi < NG; gi++)
      begin : g_gen
         localparam int CH = gi / NUM_GEN;
         localparam int EV = gi % NUM_GEN;
         wire [WORD_W-1:0] word   = pattern_word_in[CH*WORD_W +: WORD_W];
         wire [EVT_W-1:0]  evt    = store[CH][word][EV];
         wire [DLY_W-1:0]  dly    = evt[DLY_W-1:0];
         wire [CODE_W-1:0] code   = evt[CODE_LSB +: CODE_W];
         wire [SUM_W-1:0]  sum    = SUM_W'(dly) + SUM_W'(cal_r[code]) +
                                    SUM_W'(global_offset_in);
         wire              start  = pattern_qualifier_in &
                                    (alt_sel[EV] ? alternate_period_start_in :
                                     tester_period_start_in);
         wire              is_cmp = code_r[gi] >= EV_CMP_LOW;

         // Edge fires when the coarse count runs out; a new start restarts it
         assign fire_now[gi] = armed_r[gi] & pattern_qualifier_in &
                               (cnt_r[gi] == '0);

         always_ff @(posedge core_clk_in)
         begin
            if (rst || !pattern_qualifier_in)
            begin
               armed_r[gi] <= 1'b0;
               cnt_r[gi]   <= '0;
               code_r[gi]  <= EV_NONE;
               fine_r[gi]  <= '0;
            end
            else if (start)
            begin
               armed_r[gi] <= 1'b1;
               cnt_r[gi]   <= sum[SUM_W-1:VERN_W];
               code_r[gi]  <= code;
               fine_r[gi]  <= vern_map(sum[VERN_W-1:0]);
            end
            else if (fire_now[gi])
               armed_r[gi] <= 1'b0;
            else if (armed_r[gi])
               cnt_r[gi] <= cnt_r[gi] - 1'b1;
         end

         // Registered timing edge with its vernier
         always_ff @(posedge core_clk_in)
         begin
            if (rst)
            begin
               fire_r[gi] <= 1'b0;
               edge_fine_out[gi*FINE_W +: FINE_W] <= '0;
            end
            else
            begin
               fire_r[gi] <= fire_now[gi];
               edge_fine_out[gi*FINE_W +: FINE_W] <= fine_r[gi];
            end
         end

         // Compare events travel a delay line, drive events do not
         always_ff @(posedge core_clk_in)
         begin
            if (rst)
               cmp_pipe_r[gi] <= '0;
            else
               cmp_pipe_r[gi] <= {cmp_pipe_r[gi][RTC_STAGES-2:0],
                                  fire_now[gi] & is_cmp};
            cmp_code_pipe_r[gi][0] <= code_r[gi];
            for (int s = 1; s < RTC_STAGES; s++)
               cmp_code_pipe_r[gi][s] <= cmp_code_pipe_r[gi][s-1];
         end

         // Tap zero is the undelayed event; compensation adds whole steps
         assign cmp_tap[gi] = (rtc_sel == '0) ?
                              (fire_now[gi] & is_cmp) :
                              cmp_pipe_r[gi][rtc_sel - 1'b1];
         assign cmp_tap_code[gi] = (rtc_sel == '0) ? code_r[gi] :
                                   cmp_code_pipe_r[gi][rtc_sel - 1'b1];

         always_ff @(posedge core_clk_in)
         begin
            if (rst)
            begin
               strobe_r[gi]      <= 1'b0;
               strobe_code_r[gi] <= EV_NONE;
            end
            else
            begin
               strobe_r[gi]      <= cmp_tap[gi];
               strobe_code_r[gi] <= cmp_tap_code[gi];
            end
         end

         assign compare_code_out[gi*CODE_W +: CODE_W] = strobe_code_r[gi];
      end
   endgenerate

   assign edge_fire_out      = fire_r;
   assign compare_strobe_out = strobe_r;

   // Driver data, driver enable and load per channel
   logic [NUM_CH-1:0]   dd_r;
   logic [NUM_CH-1:0]   de_r;
   logic [NUM_CH-1:0]   le_r;
   logic [NUM_CH*2-1:0] win_r;

   genvar ci;
   generate
      for (ci = 0; ci < NUM_CH; ci++)
      begin : g_ch
         logic dd_nxt;
         logic de_nxt;
         logic le_nxt;
         logic [1:0] win_nxt;

         // Later generators win when several fire together
         always_comb
         begin
            dd_nxt  = dd_r[ci];
            de_nxt  = de_r[ci];
            le_nxt  = le_r[ci];
            for (int e = 0; e < NUM_GEN; e++)
            begin
               if (fire_now[ci*NUM_GEN+e])
               begin
                  case (code_r[ci*NUM_GEN+e])
                     EV_DRV_LOW:    dd_nxt = 1'b0;
                     EV_DRV_HIGH:   dd_nxt = 1'b1;
                     EV_FORCE_OFF:
                     begin
                        de_nxt = 1'b0;
                        le_nxt = 1'b1;
                     end
                     EV_FORCE_UP:
                     begin
                        de_nxt = 1'b1;
                        dd_nxt = 1'b1;
                        le_nxt = 1'b0;
                     end
                     EV_FORCE_DOWN:
                     begin
                        de_nxt = 1'b1;
                        dd_nxt = 1'b0;
                        le_nxt = 1'b0;
                     end
                     EV_FORCE_PRI:  de_nxt = 1'b1;
                     default:       dd_nxt = dd_nxt;
                  endcase
               end
            end
         end

         // Windows pair generators 0/1 and 2/3; the odd one closes
         always_comb
         begin
            win_nxt = win_r[ci*2 +: 2];
            for (int p = 0; p < 2; p++)
            begin
               if (cmp_tap[ci*NUM_GEN+2*p] &&
                   cmp_tap_code[ci*NUM_GEN+2*p] >= EV_WIN_LOW)
                  win_nxt[p] = 1'b1;
               if (cmp_tap[ci*NUM_GEN+2*p+1])
                  win_nxt[p] = 1'b0;
            end
         end

         always_ff @(posedge core_clk_in)
         begin
            if (rst)
            begin
               dd_r[ci]        <= 1'b0;
               de_r[ci]        <= 1'b0;
               le_r[ci]        <= 1'b0;
               win_r[ci*2 +: 2] <= 2'b00;
            end
            else
            begin
               dd_r[ci]        <= dd_nxt;
               de_r[ci]        <= de_nxt;
               le_r[ci]        <= le_nxt;
               win_r[ci*2 +: 2] <= win_nxt;
            end
         end
      end
   endgenerate

   assign drive_data_out   = dd_r;
   assign drive_enable_out = de_r;
   assign load_enable_out  = le_r;
   assign window_open_out  = win_r;

endmodule

// file: hw/wedg_pkg.sv
// Constants, encodings and register map of the waveform event delay generator
package wedg_pkg;

   // Structure of the block
   localparam int NUM_CH       = 4;
   localparam int NUM_GEN      = 4;
   localparam int WORD_W       = 8;
   localparam int NUM_WAVES    = 256;
   localparam int EVT_W        = 26;
   localparam int DLY_W        = 22;
   localparam int CODE_W       = 4;
   localparam int CODE_LSB     = 22;
   localparam int OFFSET_W     = 8;
   localparam int CAL_W        = 8;
   localparam int VERN_W       = 6;
   localparam int SUM_W        = 23;
   localparam int COARSE_W     = SUM_W - VERN_W;
   localparam int FINE_W       = 6;
   localparam int RTC_W        = 4;
   localparam int RTC_DEPTH    = 16;

   // Timing figures, picoseconds
   localparam int CLK_PERIOD_PS  = 50000;
   localparam int COARSE_STEP_PS = 2500;
   localparam int VERN_DIV       = 60;
   localparam int VERN_SCALE     = 64;

   // Event codes
   typedef enum logic [3:0] {
      EV_NONE       = 4'h0,
      EV_DRV_LOW    = 4'h1,
      EV_DRV_HIGH   = 4'h2,
      EV_FORCE_OFF  = 4'h3,
      EV_FORCE_UP   = 4'h4,
      EV_FORCE_DOWN = 4'h5,
      EV_FORCE_PRI  = 4'h6,
      EV_CMP_LOW    = 4'h7,
      EV_CMP_HIGH   = 4'h8,
      EV_CMP_UNK    = 4'h9,
      EV_CMP_MID    = 4'ha,
      EV_CMP_VALID  = 4'hb,
      EV_WIN_LOW    = 4'hc,
      EV_WIN_HIGH   = 4'hd,
      EV_WIN_MID    = 4'he,
      EV_WIN_VALID  = 4'hf
   } wedg_code_type;

   // Register byte offsets
   localparam logic [11:0] REG_CTRL      = 12'h000;
   localparam logic [11:0] REG_STATUS    = 12'h004;
   localparam logic [11:0] REG_WAVE_ADDR = 12'h008;
   localparam logic [11:0] REG_WAVE_DATA = 12'h00c;
   localparam logic [11:0] REG_CAL_BASE  = 12'h010;
   localparam logic [11:0] REG_CAL_LAST  = 12'h04c;

   // Control fields
   localparam int CTRL_ALT_LSB  = 0;
   localparam int CTRL_RTC_LSB  = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK  = 32'h0000_00ff;

   // Wave address fields
   localparam int WA_ENT_LSB = 0;
   localparam int WA_EVT_LSB = 8;
   localparam int WA_CH_LSB  = 10;
   localparam logic [31:0] WA_MASK = 32'h0000_0fff;

   // Status fields
   localparam int ST_DATA_LSB = 0;
   localparam int ST_EN_LSB   = 4;
   localparam int ST_LOAD_LSB = 8;
   localparam int ST_WIN_LSB  = 12;
   localparam int ST_MODE_BIT = 20;

endpackage

// file: tb/wedg_props.sv
// Port assertions for the waveform event delay generator
`timescale 1ns/100ps
module wedg_props
   import wedg_pkg::*;
(
   // Clock and reset
   input wire logic        core_clk_in,
   input wire logic        rst_in,
   // Bus and pattern side
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   input wire logic        pattern_qualifier_in,
   input wire logic        clock_generation_mode_pin_in,
   // Edge and driver outputs
   input wire logic [15:0] edge_fire_out,
   input wire logic [95:0] edge_fine_out,
   input wire logic [15:0] compare_strobe_out,
   input wire logic [63:0] compare_code_out,
   input wire logic [3:0]  drive_data_out
);
   // Per-edge flags, so one assertion covers all sixteen edges
   logic [15:0] fine_bad;
   logic [15:0] code_bad;
   logic        unmapped;
   assign unmapped = paddr_in[1:0] != 2'h0 || paddr_in > REG_CAL_LAST;
   for (genvar i = 0; i < 16; i++)
   begin : g_flag
      assign fine_bad[i] = edge_fire_out[i]
                           && edge_fine_out[6*i +: 6] > 6'h3c;
      assign code_bad[i] = compare_strobe_out[i]
                           && compare_code_out[4*i +: 4] < 4'h7;
   end

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);

   // Steps of a status read and of a dropped qualifier
   sequence rd_status;
      psel_in && penable_in && !pwrite_in && paddr_in == REG_STATUS;
   endsequence
   sequence qual_gone;
      !pattern_qualifier_in ##1 !pattern_qualifier_in;
   endsequence

   chk_no_wait: assert property (psel_in && !penable_in |=> pready_out)
      else $error("bus access stalled");
   chk_err_map: assert property (psel_in && penable_in
      |-> pslverr_out == unmapped) else $error("error flag wrong");
   chk_qual_mute: assert property (qual_gone |=> edge_fire_out == '0)
      else $error("edge fired without qualifier");
   chk_reset_quiet: assert property (disable iff (1'b0) rst_in
      |=> edge_fire_out == '0 && drive_data_out == '0)
      else $error("outputs active in reset");
   chk_strobe_code: assert property (code_bad == '0)
      else $error("strobe with a drive code");
   chk_fine_range: assert property (fine_bad == '0)
      else $error("fine value above sixty");
   chk_status_mode: assert property (rd_status |->
      prdata_out[ST_MODE_BIT] == $past(clock_generation_mode_pin_in))
      else $error("mode pin readback wrong");
   chk_status_drive: assert property (rd_status |->
      prdata_out[3:0] == $past(drive_data_out))
      else $error("drive data readback wrong");
endmodule

bind wedg_top wedg_props wedg_props_inst
(
   .core_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
   .prdata_out, .pready_out, .pslverr_out, .pattern_qualifier_in,
   .clock_generation_mode_pin_in, .edge_fire_out, .edge_fine_out,
   .compare_strobe_out, .compare_code_out, .drive_data_out
);

// file: tb/wedg_seq_model.sv
// Pattern sequencer model: words, period starts and global offset
`timescale 1ns/100ps
module wedg_seq_model
   import wedg_pkg::*;
(
   // Clock
   input  wire logic                 clk_in,
   // Sequencer side of the pattern interface
   output logic [NUM_CH*WORD_W-1:0]  word_out,
   output logic                      qual_out,
   output logic                      t_start_out,
   output logic                      a_start_out,
   output logic [OFFSET_W-1:0]       offset_out,
   output logic                      mode_pin_out
);
   // Board straps clock generation mode low
   assign mode_pin_out = 1'b0;

   // Idle until the first period
   initial
   begin
      word_out = '0;
      qual_out = 1'b0;
      t_start_out = 1'b0;
      a_start_out = 1'b0;
      offset_out = '0;
   end

   // Tester start, alternate start one cycle later; afterwards word and
   // offset are scrambled so any late sampling shows up
   task automatic period(input logic [31:0] w, input logic [7:0] off,
                         input logic q, input logic keep);
      @(posedge clk_in);
      word_out <= w;
      offset_out <= off;
      qual_out <= q;
      t_start_out <= 1'b1;
      @(posedge clk_in);
      t_start_out <= 1'b0;
      a_start_out <= 1'b1;
      @(posedge clk_in);
      a_start_out <= 1'b0;
      word_out <= ~w;
      offset_out <= ~off;
      qual_out <= q & keep;
   endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the waveform event delay generator
`timescale 1ns/100ps
module tb
   import wedg_pkg::*;
;
   // Clock, resets and bus master
   logic core_clk_in = 1'b0, rst_in = 1'b1, por_n_in = 1'b0;
   logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0, prdata_out, q;
   logic pready_out, pslverr_out, e;
   // Pattern side and outputs
   logic [31:0] pattern_word_in;
   logic [7:0]  global_offset_in, window_open_out, win_seen;
   logic pattern_qualifier_in, tester_period_start_in;
   logic alternate_period_start_in, clock_generation_mode_pin_in;
   logic [15:0] edge_fire_out, compare_strobe_out;
   logic [95:0] edge_fine_out;
   logic [63:0] compare_code_out;
   logic [3:0]  drive_data_out, drive_enable_out, load_enable_out;
   // Bookkeeping
   int err_total = 0, num_checks = 0, cyc = 0, k, fire_k[16], strb_k[16];
   logic [5:0]  fine_s[16];
   logic [3:0]  code_s[16];
   logic [7:0]  cal[16];
   logic [22:0] s;

   wedg_top wedg_top_inst
   (
      .core_clk_in, .rst_in, .por_n_in, .clock_generation_mode_pin_in,
      .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
      .prdata_out, .pready_out, .pslverr_out, .pattern_word_in,
      .pattern_qualifier_in, .tester_period_start_in,
      .alternate_period_start_in, .global_offset_in, .edge_fire_out,
      .edge_fine_out, .compare_strobe_out, .compare_code_out,
      .drive_data_out, .drive_enable_out, .load_enable_out,
      .window_open_out
   );
   wedg_seq_model wedg_seq_model_inst
   (
      .clk_in(core_clk_in), .word_out(pattern_word_in),
      .qual_out(pattern_qualifier_in), .t_start_out(tester_period_start_in),
      .a_start_out(alternate_period_start_in),
      .offset_out(global_offset_in),
      .mode_pin_out(clock_generation_mode_pin_in)
   );

   // Clock and hang guard
   always #25 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_total++;
         final_report();
      end
   end

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; read data taken at the edge that ends the access
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge core_clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge core_clk_in);
      penable_in <= 1'b1;
      do
         @(posedge core_clk_in);
      while (pready_out !== 1'b1);
      q = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   // One period; records the cycle of each fire and strobe after start
   task automatic run(input logic qv, input logic keep);
      for (int i = 0; i < 16; i++)
      begin
         fire_k[i] = -1;
         strb_k[i] = -1;
      end
      win_seen = 8'h00;
      fork
         wedg_seq_model_inst.period(32'h5958_5b5a, 8'h40, qv, keep);
         begin
            do
               @(posedge core_clk_in);
            while (tester_period_start_in !== 1'b1);
            for (int j = 1; j <= 20; j++)
            begin
               @(posedge core_clk_in);
               #1;
               win_seen = win_seen | window_open_out;
               for (int i = 0; i < 16; i++)
               begin
                  if (edge_fire_out[i] === 1'b1)
                  begin
                     fire_k[i] = (fire_k[i] == -1) ? j : 999;
                     fine_s[i] = edge_fine_out[6*i +: 6];
                  end
                  if (compare_strobe_out[i] === 1'b1)
                  begin
                     strb_k[i] = (strb_k[i] == -1) ? j : 999;
                     code_s[i] = compare_code_out[4*i +: 4];
                  end
               end
            end
         end
      join
   endtask

   // Verdict
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence: edge i carries code i on a per-channel entry
   initial
   begin
      repeat (2) @(posedge core_clk_in);
      por_n_in <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      rst_in <= 1'b0;
      apb(1'b0, REG_CTRL, 32'h0);
      chk(q, CTRL_RESET);
      apb(1'b0, 12'h050, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, REG_WAVE_DATA, 32'hffff_ffff);
      apb(1'b0, REG_WAVE_DATA, 32'h0);
      chk(q, 32'h03ff_ffff);
      for (int i = 0; i < 16; i++)
      begin
         cal[i] = (i == 2) ? 8'h50 : 8'h00;
         apb(1'b1, REG_CAL_BASE + 12'(4 * i), {24'h0, cal[i]});
         apb(1'b1, REG_WAVE_ADDR, {20'h0, 4'(i), 8'h5a ^ 8'(i / 4)});
         apb(1'b1, REG_WAVE_DATA,
             {6'h0, 4'(i), 22'((2 * (i % 4) + 1) * 64 + 4 * i)});
      end
      apb(1'b0, REG_WAVE_DATA, 32'h0);
      chk(q, 32'h03c0_01fc);
      // Generator 1 on alternate start, round trip of three cycles
      apb(1'b1, REG_CTRL, 32'h0000_0032);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(q, 32'h0000_0032);
      run(1'b1, 1'b1);
      for (int i = 0; i < 16; i++)
      begin
         s = 23'((2 * (i % 4) + 1) * 64 + 4 * i) + 23'(cal[i]) + 23'h40;
         k = 1 + int'(s[22:6]) + ((i % 4 == 1) ? 1 : 0);
         chk(32'(fire_k[i]), 32'(k));
         chk({26'h0, fine_s[i]}, (32'(s[5:0]) * 60 + 32) / 64);
         chk(32'(strb_k[i]), (i >= 7) ? 32'(k + 3) : 32'hffff_ffff);
         if (i >= 7)
            chk({28'h0, code_s[i]}, 32'(i));
      end
      chk({24'h0, win_seen}, 32'h0000_00c0);
      chk({24'h0, window_open_out}, 32'h0);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(q, 32'h0000_0121);
      chk({20'h0, load_enable_out, drive_enable_out, drive_data_out},
          32'h0000_0121);
      // Start with qualifier low, then qualifier dropped while pending
      for (int m = 0; m < 2; m++)
      begin
         run(1'(m), 1'b0);
         for (int i = 0; i < 16; i++)
            chk(32'(fire_k[i]), 32'hffff_ffff);
      end
      // Mid-run reset clears control and driver state
      @(posedge core_clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      rst_in <= 1'b0;
      apb(1'b0, REG_STATUS, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(q, CTRL_RESET);
      final_report();
   end
endmodule
